// >>> design/icc_pkg.sv
// icc_pkg: register map, field positions, encodings and types of the
// input capture channel.
// assumes: APB slave with 8-bit byte addresses and 32-bit data.
package icc_pkg;

	localparam int ICC_ADDR_W     = 8;
	localparam int ICC_DATA_W     = 32;
	localparam int ICC_TMR16_W    = 16;
	localparam int ICC_FIFO_DEPTH = 4;
	localparam int ICC_NIRQ       = 2;

	// byte offsets
	localparam logic [7:0] ICC_OFS_CTRL  = 8'h00;
	localparam logic [7:0] ICC_OFS_BUF   = 8'h10;
	localparam logic [7:0] ICC_OFS_ISTAT = 8'h20;
	localparam logic [7:0] ICC_OFS_ICLR  = 8'h24;
	localparam logic [7:0] ICC_OFS_IEN   = 8'h28;

	// control field positions
	localparam int ICC_BIT_ON    = 15;
	localparam int ICC_BIT_ISTOP = 13;
	localparam int ICC_BIT_EDGE1 = 9;
	localparam int ICC_BIT_WIDE  = 8;
	localparam int ICC_BIT_TSEL  = 7;
	localparam int ICC_BIT_EPI   = 5;
	localparam int ICC_BIT_OVF   = 4;
	localparam int ICC_BIT_BNE   = 3;
	localparam int ICC_BIT_MODE  = 0;

	localparam logic [31:0] ICC_CTRL_WMASK = 32'h0000_A3E7;
	localparam logic [31:0] ICC_CTRL_RMASK = 32'h0000_A3FF;

	// interrupt status bit positions
	localparam int ICC_IRQ_CAP = 0;
	localparam int ICC_IRQ_OVF = 1;

	// capture modes
	localparam logic [2:0] ICC_MODE_OFF  = 3'h0;
	localparam logic [2:0] ICC_MODE_FALL = 3'h2;
	localparam logic [2:0] ICC_MODE_RISE = 3'h3;
	localparam logic [2:0] ICC_MODE_ALT  = 3'h6;

	// events per interrupt
	localparam logic [1:0] ICC_EPI_EVERY1 = 2'h0;
	localparam logic [1:0] ICC_EPI_EVERY2 = 2'h1;
	localparam logic [1:0] ICC_EPI_EVERY4 = 2'h2;

	typedef struct packed {
		logic       enable;
		logic       idle_stop;
		logic       first_edge_select;
		logic       wide_capture_select;
		logic       timer_source_select;
		logic [1:0] events_per_interrupt;
		logic [2:0] capture_mode_select;
	} icc_ctrl_t;

	localparam icc_ctrl_t ICC_CTRL_RESET = '0;

	typedef enum logic [0:0] {
		ICC_ST_IDLE = 1'h0,
		ICC_ST_RESP = 1'h1
	} icc_apb_state_t;

endpackage

// >>> design/icc_edge_detect.sv
// icc_edge_detect: qualifies edges of the capture input by mode.
// assumes: cap_in synchronous to pclk; clear held while channel is off.
`timescale 1ns/1ps
`default_nettype none
module icc_edge_detect (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       ce,
	input  wire logic       clear,
	input  wire logic       run,
	input  wire logic       cap_in,
	input  wire logic [2:0] mode,
	input  wire logic       first_edge,
	output logic            cap_pulse
);

	logic prev_reg;
	logic prev_next;
	logic expect_rise_reg;
	logic expect_rise_next;
	logic rise;
	logic fall;
	logic hit;

	assign rise = cap_in & ~prev_reg;
	assign fall = ~cap_in & prev_reg;

	always_comb begin
		case (mode)
			icc_pkg::ICC_MODE_ALT:  hit = expect_rise_reg ? rise : fall; // [RULE3]
			icc_pkg::ICC_MODE_FALL: hit = fall;
			icc_pkg::ICC_MODE_RISE: hit = rise;
			icc_pkg::ICC_MODE_OFF:  hit = 1'b0;
			default:                hit = rise | fall;
		endcase
		cap_pulse = run & ~clear & hit;
		prev_next = cap_in;
		if (clear) begin
			expect_rise_next = first_edge; // [RULE3]
		end else if (cap_pulse && mode == icc_pkg::ICC_MODE_ALT) begin
			expect_rise_next = ~expect_rise_reg;
		end else begin
			expect_rise_next = expect_rise_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg        <= 1'b0;
			expect_rise_reg <= 1'b0;
		end else if (ce) begin
			prev_reg        <= prev_next;
			expect_rise_reg <= expect_rise_next;
		end
	end

	AST_ALT_EDGE_ORDER: assert property ( // [RULE3]
		@(posedge pclk) disable iff (!presetn)
		cap_pulse && mode == icc_pkg::ICC_MODE_ALT |-> rise == expect_rise_reg)
		else $error("alternating mode captured the wrong edge");

	AST_FIRST_EDGE_LOAD: assert property ( // [RULE3]
		@(posedge pclk) disable iff (!presetn)
		ce && clear |=> expect_rise_reg == $past(first_edge))
		else $error("first edge choice not loaded while disabled");

endmodule
`default_nettype wire

// >>> design/icc_fifo.sv
// icc_fifo: capture value buffer, flip-flop storage, synchronous clear.
// assumes: push is never asserted while full.
`timescale 1ns/1ps
`default_nettype none
module icc_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4,
	parameter int CW    = $clog2(DEPTH + 1),
	parameter int AW    = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             ce,
	input  wire logic             clear,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] push_data,
	input  wire logic             pop,
	output logic      [WIDTH-1:0] head,
	output logic      [CW-1:0]    count,
	output logic                  full,
	output logic                  empty
);

	logic [WIDTH-1:0] mem_reg  [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    wr_next;
	logic [AW-1:0]    rd_reg;
	logic [AW-1:0]    rd_next;
	logic [CW-1:0]    cnt_reg;
	logic [CW-1:0]    cnt_next;
	logic             do_pop;

	assign head  = mem_reg[rd_reg];
	assign count = cnt_reg;
	assign full  = (cnt_reg == CW'(DEPTH));
	assign empty = (cnt_reg == '0);
	assign do_pop = pop & ~empty;

	function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
		inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	always_comb begin
		mem_next = mem_reg;
		wr_next  = wr_reg;
		rd_next  = rd_reg;
		cnt_next = cnt_reg;
		if (clear) begin
			wr_next  = '0;
			rd_next  = '0;
			cnt_next = '0;
		end else begin
			if (push) begin
				mem_next[wr_reg] = push_data;
				wr_next = inc(wr_reg);
			end
			if (do_pop) begin
				rd_next = inc(rd_reg);
			end
			if (push && !do_pop) begin
				cnt_next = CW'(cnt_reg + 1'b1);
			end else if (!push && do_pop) begin
				cnt_next = CW'(cnt_reg - 1'b1);
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_entry
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mem_reg[g] <= '0;
				end else if (ce) begin
					mem_reg[g] <= mem_next[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else if (ce) begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

endmodule
`default_nettype wire

// >>> design/icc_top.sv
// icc_top: one input capture channel with its APB register file.
// assumes: pclk at 10 MHz; timer counts and capture input synchronous.
//
// Functional notes
// RULE1 - enable runs channel; clear resets, inhibits interrupts
// RULE2 - idle stop halts capture in Idle
// RULE3 - mode 110 first edge chosen by bit
// RULE4 - wide select takes 32-bit timer count
// RULE5 - timer select picks 16-bit timer, ignored wide
// RULE6 - interrupt after one, two or four captures
// RULE7 - overflow flag set on capture overflow
// RULE8 - nonempty flag reflects buffered values
// RULE9 - unimplemented control bits read zero
// RULE10 - software waits a cycle after disabling
// RULE11 - edge pushes timer count, full records overflow
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module icc_top #(
	parameter int FIFO_DEPTH = icc_pkg::ICC_FIFO_DEPTH
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cap_in,
	input  wire logic        idle_mode,
	input  wire logic [15:0] timer2_count,
	input  wire logic [15:0] timer3_count,
	input  wire logic [31:0] timer32_count,
	output logic             irq
);

	localparam int CW = $clog2(FIFO_DEPTH + 1);

	////////////////////////////////////////////////////////////////////////
	// state

	icc_pkg::icc_ctrl_t      ctrl_reg;
	icc_pkg::icc_ctrl_t      ctrl_next;
	icc_pkg::icc_apb_state_t st_reg;
	icc_pkg::icc_apb_state_t st_next;
	logic [31:0]             prdata_reg;
	logic [31:0]             prdata_next;
	logic                    pready_reg;
	logic                    pready_next;
	logic                    pslverr_reg;
	logic                    pslverr_next;
	logic                    pop_pend_reg;
	logic                    pop_pend_next;
	logic                    ovf_reg;
	logic                    ovf_next;
	logic [1:0]              decim_reg;
	logic [1:0]              decim_next;
	logic [1:0]              istat_reg;
	logic [1:0]              istat_next;
	logic [1:0]              ien_reg;
	logic [1:0]              ien_next;
	logic                    irq_reg;
	logic                    irq_next;

	logic          run;
	logic          clear;
	logic          cap_pulse;
	logic          cap_accept;
	logic          cap_ovf;
	logic          cap_evt;
	logic [1:0]    decim_top;
	logic [31:0]   push_data;
	logic [31:0]   fifo_head;
	logic [CW-1:0] fifo_count;
	logic          fifo_full;
	logic          fifo_empty;
	logic          access;
	logic          done;
	logic          wr_done;
	logic          pop;
	logic [31:0]   ctrl_word;
	logic [1:0]    clr_mask;

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq     = irq_reg;

	////////////////////////////////////////////////////////////////////////
	// capture path

	assign clear = ~ctrl_reg.enable; // [RULE1]
	assign run   = ctrl_reg.enable &
		~(ctrl_reg.idle_stop & idle_mode); // [RULE2]

	icc_edge_detect u_edge (
		.pclk       (pclk),
		.presetn    (presetn),
		.ce         (ce),
		.clear      (clear),
		.run        (run),
		.cap_in     (cap_in),
		.mode       (ctrl_reg.capture_mode_select),
		.first_edge (ctrl_reg.first_edge_select),
		.cap_pulse  (cap_pulse)
	);

	always_comb begin
		if (ctrl_reg.wide_capture_select) begin
			push_data = timer32_count; // [RULE4] [RULE5]
		end else if (ctrl_reg.timer_source_select) begin
			push_data = {16'h0000, timer2_count}; // [RULE5]
		end else begin
			push_data = {16'h0000, timer3_count}; // [RULE5]
		end
	end

	assign cap_accept = cap_pulse & ~fifo_full; // [RULE11]
	assign cap_ovf    = cap_pulse & fifo_full;  // [RULE11]

	icc_fifo #(
		.WIDTH (32),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.clear     (clear),
		.push      (cap_accept),
		.push_data (push_data),
		.pop       (pop),
		.head      (fifo_head),
		.count     (fifo_count),
		.full      (fifo_full),
		.empty     (fifo_empty)
	);

	////////////////////////////////////////////////////////////////////////
	// decimation, overflow and interrupt status

	always_comb begin
		case (ctrl_reg.events_per_interrupt) // [RULE6]
			icc_pkg::ICC_EPI_EVERY1: decim_top = 2'h0;
			icc_pkg::ICC_EPI_EVERY2: decim_top = 2'h1;
			icc_pkg::ICC_EPI_EVERY4: decim_top = 2'h3;
			default:                 decim_top = 2'h3;
		endcase
		cap_evt    = cap_accept && decim_reg >= decim_top; // [RULE6]
		decim_next = decim_reg;
		if (clear) begin
			decim_next = 2'h0;
		end else if (cap_accept) begin
			decim_next = cap_evt ? 2'h0 : 2'(decim_reg + 1'b1);
		end
		ovf_next = clear ? 1'b0 : (ovf_reg | cap_ovf); // [RULE7] [RULE1]
		// a new event wins over a clear written in the same cycle
		istat_next = (istat_reg & ~clr_mask) | {cap_ovf, cap_evt}; // [RULE1]
		irq_next   = |(istat_next & ien_next);
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave, one wait state

	assign access  = psel & penable;
	assign done    = access & (st_reg == icc_pkg::ICC_ST_RESP);
	assign wr_done = done & pwrite;
	assign pop     = done & ~pwrite & pop_pend_reg;

	always_comb begin
		ctrl_word = '0; // [RULE9]
		ctrl_word[icc_pkg::ICC_BIT_ON]    = ctrl_reg.enable;
		ctrl_word[icc_pkg::ICC_BIT_ISTOP] = ctrl_reg.idle_stop;
		ctrl_word[icc_pkg::ICC_BIT_EDGE1] = ctrl_reg.first_edge_select;
		ctrl_word[icc_pkg::ICC_BIT_WIDE]  = ctrl_reg.wide_capture_select;
		ctrl_word[icc_pkg::ICC_BIT_TSEL]  = ctrl_reg.timer_source_select;
		ctrl_word[icc_pkg::ICC_BIT_EPI +: 2] =
			ctrl_reg.events_per_interrupt;
		ctrl_word[icc_pkg::ICC_BIT_OVF]  = ovf_reg;      // [RULE7]
		ctrl_word[icc_pkg::ICC_BIT_BNE]  = ~fifo_empty;  // [RULE8]
		ctrl_word[icc_pkg::ICC_BIT_MODE +: 3] =
			ctrl_reg.capture_mode_select;
	end

	always_comb begin
		st_next       = st_reg;
		pready_next   = 1'b0;
		prdata_next   = prdata_reg;
		pslverr_next  = 1'b0;
		pop_pend_next = 1'b0;
		ctrl_next     = ctrl_reg;
		ien_next      = ien_reg;
		clr_mask      = 2'h0;
		case (st_reg)
			icc_pkg::ICC_ST_IDLE: begin
				if (access) begin
					st_next     = icc_pkg::ICC_ST_RESP;
					pready_next = 1'b1;
					prdata_next = 32'h0000_0000;
					case (paddr)
						icc_pkg::ICC_OFS_CTRL: begin
							prdata_next = ctrl_word & icc_pkg::ICC_CTRL_RMASK;
						end
						icc_pkg::ICC_OFS_BUF: begin
							prdata_next   = fifo_empty ? 32'h0000_0000
								: fifo_head;
							pop_pend_next = ~pwrite & ~fifo_empty;
						end
						icc_pkg::ICC_OFS_ISTAT: prdata_next = {30'h0, istat_reg};
						icc_pkg::ICC_OFS_ICLR:  prdata_next = 32'h0000_0000;
						icc_pkg::ICC_OFS_IEN:   prdata_next = {30'h0, ien_reg};
						default:                pslverr_next = 1'b1;
					endcase
				end
			end
			icc_pkg::ICC_ST_RESP: begin
				st_next = icc_pkg::ICC_ST_IDLE;
				if (wr_done) begin
					case (paddr)
						icc_pkg::ICC_OFS_CTRL: begin
							ctrl_next = icc_pkg::icc_ctrl_t'({
								pwdata[icc_pkg::ICC_BIT_ON],
								pwdata[icc_pkg::ICC_BIT_ISTOP],
								pwdata[icc_pkg::ICC_BIT_EDGE1],
								pwdata[icc_pkg::ICC_BIT_WIDE],
								pwdata[icc_pkg::ICC_BIT_TSEL],
								pwdata[icc_pkg::ICC_BIT_EPI +: 2],
								pwdata[icc_pkg::ICC_BIT_MODE +: 3]});
						end
						icc_pkg::ICC_OFS_ICLR: clr_mask = pwdata[1:0];
						icc_pkg::ICC_OFS_IEN:  ien_next = pwdata[1:0];
						default: ;
					endcase
				end
			end
			default: st_next = icc_pkg::ICC_ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg     <= icc_pkg::ICC_CTRL_RESET;
			st_reg       <= icc_pkg::ICC_ST_IDLE;
			prdata_reg   <= 32'h0000_0000;
			pready_reg   <= 1'b0;
			pslverr_reg  <= 1'b0;
			pop_pend_reg <= 1'b0;
			ovf_reg      <= 1'b0;
			decim_reg    <= 2'h0;
			istat_reg    <= 2'h0;
			ien_reg      <= 2'h0;
			irq_reg      <= 1'b0;
		end else if (ce) begin
			ctrl_reg     <= ctrl_next;
			st_reg       <= st_next;
			prdata_reg   <= prdata_next;
			pready_reg   <= pready_next;
			pslverr_reg  <= pslverr_next;
			pop_pend_reg <= pop_pend_next;
			ovf_reg      <= ovf_next;
			decim_reg    <= decim_next;
			istat_reg    <= istat_next;
			ien_reg      <= ien_next;
			irq_reg      <= irq_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	AST_DISABLE_FLUSH: assert property ( // [RULE1]
		@(posedge pclk) disable iff (!presetn)
		ce && !ctrl_reg.enable |=> fifo_empty && !ovf_reg && decim_reg == 2'h0)
		else $error("disabled channel kept buffered state");

	AST_DISABLE_NO_EVT: assert property ( // [RULE1]
		@(posedge pclk) disable iff (!presetn)
		!ctrl_reg.enable |-> !cap_evt && !cap_ovf)
		else $error("event raised while channel disabled");

	AST_IDLE_HALT: assert property ( // [RULE2]
		@(posedge pclk) disable iff (!presetn)
		ctrl_reg.idle_stop && idle_mode |-> !cap_pulse)
		else $error("capture taken in idle with idle stop set");

	AST_WIDE_SRC: assert property ( // [RULE4] [RULE5]
		@(posedge pclk) disable iff (!presetn)
		ctrl_reg.wide_capture_select |-> push_data == timer32_count)
		else $error("wide capture not from 32-bit timer");

	AST_NARROW_SRC: assert property ( // [RULE5]
		@(posedge pclk) disable iff (!presetn)
		!ctrl_reg.wide_capture_select && !ctrl_reg.timer_source_select
		|-> push_data == {16'h0000, timer3_count})
		else $error("timer select zero did not pick timer three");

	AST_DECIM_EVERY1: assert property ( // [RULE6]
		@(posedge pclk) disable iff (!presetn)
		cap_accept && ctrl_reg.events_per_interrupt == 2'h0 |-> cap_evt)
		else $error("capture without interrupt in every-capture mode");

	AST_DECIM_EVERY4: assert property ( // [RULE6]
		@(posedge pclk) disable iff (!presetn)
		cap_evt && ctrl_reg.events_per_interrupt == 2'h2
		|-> decim_reg == 2'h3)
		else $error("fourth-capture interrupt at wrong count");

	AST_OVF_SET: assert property ( // [RULE7] [RULE11]
		@(posedge pclk) disable iff (!presetn)
		ce && cap_pulse && fifo_full |=> ovf_reg && istat_reg[1])
		else $error("overflow not recorded");

	AST_PUSH_FILLS: assert property ( // [RULE8] [RULE11]
		@(posedge pclk) disable iff (!presetn)
		ce && cap_accept && fifo_empty |=> !fifo_empty)
		else $error("accepted capture left buffer empty");

	AST_CTRL_RESERVED: assert property ( // [RULE9]
		@(posedge pclk) disable iff (!presetn)
		pready_reg && $past(paddr) == icc_pkg::ICC_OFS_CTRL
		|-> (prdata_reg & ~icc_pkg::ICC_CTRL_RMASK) == 32'h0000_0000)
		else $error("unimplemented control bits read nonzero");

	AST_APB_ONE_WAIT: assert property (
		@(posedge pclk) disable iff (!presetn)
		ce && access && st_reg == icc_pkg::ICC_ST_IDLE |=> pready_reg)
		else $error("APB answer not one cycle after access");

	AST_IRQ_LEVEL: assert property (
		@(posedge pclk) disable iff (!presetn)
		ce && |(istat_next & ien_next) |=> irq)
		else $error("enabled status did not raise irq");

	COV_OVERFLOW: cover property (
		@(posedge pclk) disable iff (!presetn) cap_ovf);
	COV_DECIM4: cover property (
		@(posedge pclk) disable iff (!presetn)
		cap_evt && ctrl_reg.events_per_interrupt == 2'h2);
	COV_BUF_POP: cover property (
		@(posedge pclk) disable iff (!presetn) pop ##1 !fifo_empty);

endmodule
`default_nettype wire

// >>> test/icc_cap_model.sv
// icc_cap_model: capture input source and timer counts for the channel.
// assumes: requests change right after pclk rises; they land one edge later.
`timescale 1ns/1ps
`default_nettype none
module icc_cap_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        lvl_req,
	input  wire logic [15:0] base_req,
	output logic             cap_in,
	output logic [15:0]      timer2_count,
	output logic [15:0]      timer3_count,
	output logic [31:0]      timer32_count
);
	logic [15:0] base_reg;

	// timers and input move together, so a capture sees a settled count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_in   <= 1'b0;
			base_reg <= 16'h0000;
		end else begin
			cap_in   <= lvl_req;
			base_reg <= base_req;
		end
	end

	// each source differs so a wrong selection is seen
	assign timer3_count  = base_reg;
	assign timer2_count  = base_reg ^ 16'h00FF;
	assign timer32_count = {~base_reg, base_reg};
endmodule
`default_nettype wire

// >>> test/input_capture_control_test.sv
// input_capture_control_test: register level tests of the capture channel.
// assumes: icc_top with APB slave, icc_cap_model at the capture side.
`timescale 1ns/1ps
`default_nettype none
module input_capture_control_test;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cap_in;
	logic        idle_mode;
	logic [15:0] t2;
	logic [15:0] t3;
	logic [31:0] t32;
	logic        irq;
	logic        lvl_req;
	logic [15:0] base_req;
	logic [31:0] rv;
	logic        err;
	int          n_errors;
	int          num_checks;

	icc_top u_icc_top (.pclk(pclk), .presetn(presetn), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cap_in(cap_in), .idle_mode(idle_mode),
		.timer2_count(t2), .timer3_count(t3), .timer32_count(t32),
		.irq(irq));
	icc_cap_model u_icc_cap_model (.pclk(pclk), .presetn(presetn),
		.lvl_req(lvl_req), .base_req(base_req), .cap_in(cap_in),
		.timer2_count(t2), .timer3_count(t3), .timer32_count(t32));

	always #50 pclk = ~pclk;

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] s,
			input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// one APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (i >= 50)
			n_errors++;
		rv = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic cap(input logic v, input logic [15:0] b);
		@(posedge pclk);
		lvl_req  <= v;
		base_req <= b;
		repeat (3) @(posedge pclk);
	endtask

	task automatic pulse(input logic [15:0] b);
		cap(1'b1, b);
		cap(1'b0, b);
	endtask

	function automatic logic [31:0] ctl(logic on, logic istop, logic fe,
			logic wd, logic ts, logic [1:0] epi, logic [2:0] md);
		return (32'(on) << icc_pkg::ICC_BIT_ON)
			| (32'(istop) << icc_pkg::ICC_BIT_ISTOP)
			| (32'(fe) << icc_pkg::ICC_BIT_EDGE1)
			| (32'(wd) << icc_pkg::ICC_BIT_WIDE)
			| (32'(ts) << icc_pkg::ICC_BIT_TSEL)
			| (32'(epi) << icc_pkg::ICC_BIT_EPI) | 32'(md);
	endfunction

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		end_sim();
	end

	initial begin
		logic [31:0] ex;
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		idle_mode = 1'b0;
		lvl_req = 1'b0;
		base_req = 16'h0000;
		n_errors = 0;
		num_checks = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(icc_pkg::ICC_OFS_CTRL);
		chk("ctrl reset", rv, 32'h0000_0000);
		wr(icc_pkg::ICC_OFS_CTRL, 32'hFFFF_FFFF);
		rd(icc_pkg::ICC_OFS_CTRL);
		chk("ctrl ones", rv, 32'h0000_A3E7);
		wr(icc_pkg::ICC_OFS_CTRL, 32'h0000_0000);
		wr(icc_pkg::ICC_OFS_IEN, 32'h0000_0003);
		$display("test registers done");
		for (int k = 0; k < 3; k++) begin
			wr(icc_pkg::ICC_OFS_CTRL, ctl(1, 0, 0, k == 2, k > 0, 0, 3'h3));
			pulse(16'h1234 + 16'(k));
			ex = (k == 0) ? 32'h0000_1234 : (k == 1) ? 32'h0000_12CA
				: 32'hEDC9_1236;
			chk("irq", {31'h0, irq}, 32'h0000_0001);
			rd(icc_pkg::ICC_OFS_CTRL);
			chk("nonempty", {31'h0, rv[3]}, 32'h0000_0001);
			rd(icc_pkg::ICC_OFS_BUF);
			chk("capture", rv, ex);
			rd(icc_pkg::ICC_OFS_CTRL);
			chk("empty", {31'h0, rv[3]}, 32'h0000_0000);
			wr(icc_pkg::ICC_OFS_ICLR, 32'h0000_0003);
			@(posedge pclk);
			chk("irq clr", {31'h0, irq}, 32'h0000_0000);
			wr(icc_pkg::ICC_OFS_CTRL, 32'h0000_0000);
			@(posedge pclk);
		end
		$display("test source done");
		for (int c = 0; c < 3; c++) begin
			wr(icc_pkg::ICC_OFS_CTRL, 32'h0000_0000);
			wr(icc_pkg::ICC_OFS_ICLR, 32'h0000_0003);
			wr(icc_pkg::ICC_OFS_CTRL, ctl(1, 0, 0, 0, 0, 2'(c), 3'h3));
			for (int j = 1; j <= (1 << c); j++) begin
				pulse(16'h0100);
				rd(icc_pkg::ICC_OFS_ISTAT);
				chk("decim", rv, 32'(j == (1 << c)));
			end
		end
		pulse(16'h0200);
		rd(icc_pkg::ICC_OFS_CTRL);
		chk("ovf", rv & 32'h0000_0018, 32'h0000_0018);
		rd(icc_pkg::ICC_OFS_ISTAT);
		chk("ovf stat", rv, 32'h0000_0003);
		wr(icc_pkg::ICC_OFS_IEN, 32'h0000_0000);
		@(posedge pclk);
		chk("masked", {31'h0, irq}, 32'h0000_0000);
		wr(icc_pkg::ICC_OFS_IEN, 32'h0000_0003);
		wr(icc_pkg::ICC_OFS_CTRL, 32'h0000_0000);
		@(posedge pclk);
		rd(icc_pkg::ICC_OFS_CTRL);
		chk("flush", rv, 32'h0000_0000);
		wr(icc_pkg::ICC_OFS_ICLR, 32'h0000_0003);
		$display("test decimation done");
		wr(icc_pkg::ICC_OFS_CTRL, ctl(0, 0, 0, 0, 0, 0, 3'h3));
		pulse(16'h0300);
		rd(icc_pkg::ICC_OFS_ISTAT);
		chk("off stat", rv, 32'h0000_0000);
		chk("off irq", {31'h0, irq}, 32'h0000_0000);
		idle_mode <= 1'b1;
		wr(icc_pkg::ICC_OFS_CTRL, ctl(1, 1, 0, 0, 0, 0, 3'h3));
		pulse(16'h0400);
		rd(icc_pkg::ICC_OFS_CTRL);
		chk("idle halt", {31'h0, rv[3]}, 32'h0000_0000);
		wr(icc_pkg::ICC_OFS_CTRL, ctl(1, 0, 0, 0, 0, 0, 3'h3));
		pulse(16'h0500);
		rd(icc_pkg::ICC_OFS_CTRL);
		chk("idle run", {31'h0, rv[3]}, 32'h0000_0001);
		idle_mode <= 1'b0;
		$display("test idle done");
		for (int f = 0; f < 2; f++) begin
			wr(icc_pkg::ICC_OFS_CTRL, ctl(0, 0, f, 0, 0, 0, 3'h6));
			@(posedge pclk);
			wr(icc_pkg::ICC_OFS_CTRL, ctl(1, 0, f, 0, 0, 0, 3'h6));
			// rising and falling edges carry different counts
			cap(1'b1, 16'h0A01);
			cap(1'b0, 16'h0A00);
			rd(icc_pkg::ICC_OFS_BUF);
			chk("first edge", rv, f ? 32'h0000_0A01 : 32'h0000_0A00);
			rd(icc_pkg::ICC_OFS_BUF);
			chk("second edge", rv, f ? 32'h0000_0A00 : 32'h0000_0000);
		end
		wr(icc_pkg::ICC_OFS_CTRL, 32'h0000_0000);
		@(posedge pclk);
		wr(icc_pkg::ICC_OFS_CTRL, ctl(1, 0, 0, 0, 0, 0, 3'h2));
		cap(1'b1, 16'h0B01);
		cap(1'b0, 16'h0B00);
		rd(icc_pkg::ICC_OFS_BUF);
		chk("fall only", rv, 32'h0000_0B00);
		rd(icc_pkg::ICC_OFS_BUF);
		chk("fall empty", rv, 32'h0000_0000);
		wr(icc_pkg::ICC_OFS_CTRL, 32'h0000_0000);
		@(posedge pclk);
		wr(icc_pkg::ICC_OFS_CTRL, ctl(1, 0, 0, 0, 0, 0, 3'h7));
		cap(1'b1, 16'h0C01);
		cap(1'b0, 16'h0C00);
		rd(icc_pkg::ICC_OFS_BUF);
		chk("any edge 1", rv, 32'h0000_0C01);
		rd(icc_pkg::ICC_OFS_BUF);
		chk("any edge 2", rv, 32'h0000_0C00);
		rd(8'h0C);
		chk("unmapped", {31'h0, err}, 32'h0000_0001);
		$display("test alternate done");
		end_sim();
	end
endmodule
`default_nettype wire
